// ==== hdl/pcb_regs.v ====
// phase 4..7 current balance gain and offset registers
`include "pcb_consts.vh"
module pcb_regs (
  input  wire                     clk_sys_i,
  input  wire                     resetn_i,
  input  wire                     wr_en_i,
  input  wire                     rd_en_i,
  input  wire [`PCB_ADDR_W-1:0]   addr_i,
  input  wire [`PCB_DATA_W-1:0]   wr_data_i,
  input  wire [`PCB_TRIM_W-1:0]   trim_p4_i,
  input  wire [`PCB_TRIM_W-1:0]   trim_p5_i,
  input  wire [`PCB_TRIM_W-1:0]   trim_p6_i,
  output reg  [`PCB_DATA_W-1:0]   rd_data_o,
  output reg                      rd_valid_o,
  output wire [2:0]               p4_offset_o,
  output wire [2:0]               p5_gain_o,
  output wire [2:0]               p5_offset_o,
  output wire [2:0]               p6_gain_o,
  output wire [2:0]               p6_offset_o,
  output wire [2:0]               p7_gain_o
);

  // ----------------------------------------
  // register selects
  // ----------------------------------------
  // one-hot, one bit per stored field
  localparam [5:0] SEL_NONE    = 6'h00;
  localparam [5:0] SEL_P4_OFS  = 6'h01;
  localparam [5:0] SEL_P5_GAIN = 6'h02;
  localparam [5:0] SEL_P5_OFS  = 6'h04;
  localparam [5:0] SEL_P6_GAIN = 6'h08;
  localparam [5:0] SEL_P6_OFS  = 6'h10;
  localparam [5:0] SEL_P7_GAIN = 6'h20;

  // sizes of the trim path
  localparam       TW          = `PCB_TRIM_W;
  localparam       NPH         = 3;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one decode serves read and write so both always agree on the map
  reg [5:0] rsel;
  always @* begin
    rsel = SEL_NONE;
    if (addr_i == `PCB_ADDR_P4_OFS) begin
      rsel = SEL_P4_OFS;
    end else if (addr_i == `PCB_ADDR_P5_GAIN) begin
      rsel = SEL_P5_GAIN;
    end else if (addr_i == `PCB_ADDR_P5_OFS) begin
      rsel = SEL_P5_OFS;
    end else if (addr_i == `PCB_ADDR_P6_GAIN) begin
      rsel = SEL_P6_GAIN;
    end else if (addr_i == `PCB_ADDR_P6_OFS) begin
      rsel = SEL_P6_OFS;
    end else if (addr_i == `PCB_ADDR_P7_GAIN) begin
      rsel = SEL_P7_GAIN;
    end
  end

  // unmapped addresses leave every select low, so such writes vanish
  reg [5:0] wsel;
  always @* begin
    wsel = SEL_NONE;
    if (wr_en_i) begin
      wsel = rsel;
    end
  end

  wire [2:0] wr_gain = wr_data_i[`PCB_GAIN_MSB:`PCB_GAIN_LSB];
  // trim bits of offset writes and bit 7 of the write data are never looked at
  wire [2:0] wr_ofs  = wr_data_i[`PCB_OFS_MSB:`PCB_OFS_LSB];

  // ----------------------------------------
  // trim capture
  // ----------------------------------------
  // fuse words come from outside the clock domain: two flops each.
  // limitation: a word that changes while it is read may show torn bits
  wire [NPH*TW-1:0] trim_raw = {trim_p6_i, trim_p5_i, trim_p4_i};
  wire [NPH*TW-1:0] trim_sync;
  genvar g;
  generate
    for (g = 0; g < NPH; g = g + 1) begin : g_trim
      reg [TW-1:0] meta_reg;
      reg [TW-1:0] sync_reg;

      always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_reg <= {TW{1'b0}};
          sync_reg <= {TW{1'b0}};
        end else begin
          meta_reg <= trim_raw[g*TW +: TW];
          sync_reg <= meta_reg;
        end
      end
      assign trim_sync[g*TW +: TW] = sync_reg;
    end
  endgenerate

  wire [TW-1:0] trim_p4 = trim_sync[TW-1:0];
  wire [TW-1:0] trim_p5 = trim_sync[2*TW-1:TW];
  wire [TW-1:0] trim_p6 = trim_sync[3*TW-1:2*TW];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  pcb_field #(.RST_VAL(`PCB_OFS_RST)) u_p4_ofs (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[0]),
    .wr_data_i (wr_ofs),
    .field_o   (p4_offset_o)
  );
  pcb_field #(.RST_VAL(`PCB_GAIN_RST)) u_p5_gain (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[1]),
    .wr_data_i (wr_gain),
    .field_o   (p5_gain_o)
  );
  pcb_field #(.RST_VAL(`PCB_OFS_RST)) u_p5_ofs (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[2]),
    .wr_data_i (wr_ofs),
    .field_o   (p5_offset_o)
  );
  pcb_field #(.RST_VAL(`PCB_GAIN_RST)) u_p6_gain (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[3]),
    .wr_data_i (wr_gain),
    .field_o   (p6_gain_o)
  );
  pcb_field #(.RST_VAL(`PCB_OFS_RST)) u_p6_ofs (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[4]),
    .wr_data_i (wr_ofs),
    .field_o   (p6_offset_o)
  );
  pcb_field #(.RST_VAL(`PCB_GAIN_RST)) u_p7_gain (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (wsel[5]),
    .wr_data_i (wr_gain),
    .field_o   (p7_gain_o)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // readback words; unused upper bits read as zero
  wire [`PCB_DATA_W-1:0] rb_p4_ofs  = {1'b0, p4_offset_o, trim_p4};
  wire [`PCB_DATA_W-1:0] rb_p5_gain = {5'h00, p5_gain_o};
  wire [`PCB_DATA_W-1:0] rb_p5_ofs  = {1'b0, p5_offset_o, trim_p5};
  wire [`PCB_DATA_W-1:0] rb_p6_gain = {5'h00, p6_gain_o};
  wire [`PCB_DATA_W-1:0] rb_p6_ofs  = {1'b0, p6_offset_o, trim_p6};
  wire [`PCB_DATA_W-1:0] rb_p7_gain = {5'h00, p7_gain_o};

  reg [`PCB_DATA_W-1:0] rd_next;
  always @* begin
    case (rsel)
      SEL_P4_OFS: begin
        rd_next = rb_p4_ofs;
      end
      SEL_P5_GAIN: begin
        rd_next = rb_p5_gain;
      end
      SEL_P5_OFS: begin
        rd_next = rb_p5_ofs;
      end
      SEL_P6_GAIN: begin
        rd_next = rb_p6_gain;
      end
      SEL_P6_OFS: begin
        rd_next = rb_p6_ofs;
      end
      SEL_P7_GAIN: begin
        rd_next = rb_p7_gain;
      end
      default: begin
        rd_next = {`PCB_DATA_W{1'b0}};
      end
    endcase
  end

  // ----------------------------------------
  // read response
  // ----------------------------------------
  // valid pulse follows every strobe, mapped address or not
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
    end
  end

  // data holds between reads so a slow host can still pick it up
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= {`PCB_DATA_W{1'b0}};
    end else if (rd_en_i) begin
      rd_data_o <= rd_next;
    end
  end
endmodule

// ==== hdl/pcb_consts.vh ====
// register map and field layout of the phase current balance slice
`ifndef PCB_CONSTS_VH
`define PCB_CONSTS_VH
`define PCB_ADDR_W         8
`define PCB_DATA_W         8
`define PCB_ADDR_P4_OFS    8'h18
`define PCB_ADDR_P5_GAIN   8'h19
`define PCB_ADDR_P5_OFS    8'h1A
`define PCB_ADDR_P6_GAIN   8'h1B
`define PCB_ADDR_P6_OFS    8'h1C
`define PCB_ADDR_P7_GAIN   8'h1D
`define PCB_GAIN_MSB       2
`define PCB_GAIN_LSB       0
`define PCB_OFS_MSB        6
`define PCB_OFS_LSB        4
`define PCB_TRIM_MSB       3
`define PCB_TRIM_LSB       0
`define PCB_GAIN_RST       3'h4
`define PCB_OFS_RST        3'h0
`define PCB_TRIM_W         4
`define PCB_STEP_MV        30
`endif

// ==== hdl/pcb_field.v ====
// one read-write three-bit configuration field with reset value
module pcb_field #(
  parameter [2:0] RST_VAL = 3'h0
) (
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  input  wire       wr_en_i,
  input  wire [2:0] wr_data_i,
  output reg  [2:0] field_o
);
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      field_o <= RST_VAL;
    end else if (wr_en_i) begin
      field_o <= wr_data_i;
    end
  end
endmodule

// ==== tb/pcb_regs_monitor.sv ====
// concurrent checks on the balance register port
module pcb_regs_monitor (
  input wire logic       clk_sys_i, resetn_i, wr_en_i, rd_en_i, rd_valid_o,
  input wire logic [7:0] addr_i, wr_data_i, rd_data_o,
  input wire logic [3:0] trim_p4_i, trim_p5_i, trim_p6_i,
  input wire logic [2:0] p4_offset_o, p5_gain_o, p5_offset_o, p6_gain_o, p6_offset_o, p7_gain_o
);
  timeunit 1ns; timeprecision 1ps;
  wire [2:0] lo = wr_data_i[2:0];
  wire [2:0] hi = wr_data_i[6:4];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_p5_gain_wr: assert property (wr_en_i && addr_i == 8'h19 |=> p5_gain_o == $past(lo))
    else $error("p5 gain");
  a_p6_gain_wr: assert property (wr_en_i && addr_i == 8'h1B |=> p6_gain_o == $past(lo))
    else $error("p6 gain");
  a_p7_gain_wr: assert property (wr_en_i && addr_i == 8'h1D |=> p7_gain_o == $past(lo))
    else $error("p7 gain");
  a_p6_ofs_wr: assert property (wr_en_i && addr_i == 8'h1C |=> p6_offset_o == $past(hi))
    else $error("p6 offset");
  a_p5_ofs_wr: assert property (wr_en_i && addr_i == 8'h1A |=> p5_offset_o == $past(hi))
    else $error("p5 offset");
  a_p4_ofs_wr: assert property (wr_en_i && addr_i == 8'h18 |=> p4_offset_o == $past(hi))
    else $error("p4 offset");
  a_p4_trim_rd: assert property (rd_en_i && addr_i == 8'h18 |=> rd_valid_o &&
    rd_data_o == {1'b0, $past(p4_offset_o), $past(trim_p4_i)}) else $error("p4 read");
  a_p5_trim_rd: assert property (rd_en_i && addr_i == 8'h1A |=> rd_valid_o &&
    rd_data_o == {1'b0, $past(p5_offset_o), $past(trim_p5_i)}) else $error("p5 read");
  a_p6_trim_rd: assert property (rd_en_i && addr_i == 8'h1C |=> rd_valid_o &&
    rd_data_o == {1'b0, $past(p6_offset_o), $past(trim_p6_i)}) else $error("p6 read");
  a_p7_gain_rd: assert property (rd_en_i && addr_i == 8'h1D |=> rd_valid_o &&
    rd_data_o == {5'h00, $past(p7_gain_o)}) else $error("p7 read");
endmodule
bind pcb_regs pcb_regs_monitor mon (.*);

// ==== tb/pcb_host.sv ====
// register port host standing in for the serial programming engine
module pcb_host (
  input  wire logic       clk_sys_i,
  output logic            wr_en_o, rd_en_o,
  output logic [7:0]      addr_o, wr_data_o
);
  timeunit 1ns; timeprecision 1ps;
  initial {wr_en_o, rd_en_o, addr_o, wr_data_o} = 18'h0;
  // one access: held from just after an edge until the taking edge
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys_i);
    #1 {wr_en_o, rd_en_o, addr_o, wr_data_o} = {w, !w, a, d};
    @(posedge clk_sys_i);
    #1 {wr_en_o, rd_en_o} = 2'b00;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the phase balance registers
module testbench;
  timeunit 1ns; timeprecision 1ps;
  logic clk_sys_i = 0, resetn_i = 0, v, we, re;
  logic [3:0] t4, t5, t6;
  logic [7:0] rd, a, d, ad, wd;
  logic [2:0] m [0:7];
  logic [2:0] o4, g5, o5, g6, o6, g7;
  int bad_count = 0, checks = 0;
  pcb_host host (.clk_sys_i(clk_sys_i), .wr_en_o(we), .rd_en_o(re), .addr_o(ad), .wr_data_o(wd));
  pcb_regs dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wr_en_i(we), .rd_en_i(re),
    .addr_i(ad), .wr_data_i(wd), .trim_p4_i(t4), .trim_p5_i(t5), .trim_p6_i(t6),
    .rd_data_o(rd), .rd_valid_o(v), .p4_offset_o(o4), .p5_gain_o(g5), .p5_offset_o(o5),
    .p6_gain_o(g6), .p6_offset_o(o6), .p7_gain_o(g7));
  function logic [7:0] ex(input logic [7:0] a);
    case (a)
      8'h18: ex = {1'b0, m[0], t4};
      8'h1A: ex = {1'b0, m[2], t5};
      8'h1C: ex = {1'b0, m[4], t6};
      8'h19, 8'h1B, 8'h1D: ex = {5'h0, m[a[2:0]]};
      default: ex = 8'h00;
    endcase
  endfunction
  task chk(input logic [17:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task rdchk(input logic [7:0] a);
    host.acc(0, a, 8'h00);
    chk({7'h0, v}, 8'h01);
    chk(rd, ex(a));
    chk({o4, g5, o5, g6, o6, g7}, {m[0], m[1], m[2], m[3], m[4], m[5]});
  endtask
  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #200000 bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h7b17f832));
    {t4, t5, t6} = 12'($urandom);
    for (int i = 0; i < 8; i++) m[i] = i[0] ? 3'h4 : 3'h0;
    repeat (10) @(posedge clk_sys_i);
    #1 resetn_i = 1;
    // let the two-flop trim capture settle before the first read
    repeat (2) @(posedge clk_sys_i);
    // reset values, then unmapped 0x1E and 0x1F
    for (int i = 0; i < 8; i++) rdchk(8'h18 + 8'(i));
    // all-ones first so trim and bit 7 writes are exercised
    for (int i = 0; i < 60; i++) begin
      a = 8'h17 + 8'($urandom % 8);
      d = i < 8 ? 8'hFF : 8'($urandom);
      host.acc(1, a, d);
      if (a inside {[8'h18:8'h1D]}) m[a[2:0]] = a[0] ? d[2:0] : d[6:4];
      rdchk(a);
    end
    end_of_test();
  end
endmodule
